//--- ppt_defs.vh
// register map, field positions and reset values for parallel ports c, d and e
`ifndef PPT_DEFS_VH
`define PPT_DEFS_VH
// register indices; byte address is four times the index
`define PPT_IDX_LATCH_C 8'h02
`define PPT_IDX_LATCH_D 8'h03
`define PPT_IDX_DIR_C 8'h06
`define PPT_IDX_DIR_D 8'h07
`define PPT_IDX_LATCH_E 8'h08
`define PPT_IDX_DIR_E 8'h0C
`define PPT_IDX_PERIPH 8'h10
`define PPT_IDX_PINS 8'h11
// direction c register: clock-out enable in bit 7
`define PPT_CLKOUT_BIT 7
`define PPT_CLKOUT_PIN 2
// peripheral control register fields
`define PPT_PF_CHAN_LO 0
`define PPT_PF_CHAN_HI 4
`define PPT_PF_PRESC_LO 5
`define PPT_PF_PRESC_HI 7
`define PPT_PF_SPE 8
`define PPT_PF_SPMST 9
`define PPT_PF_MODF 10
`define PPT_PF_ELS0_LO 11
`define PPT_PF_ELS1_LO 13
`define PPT_PF_SCIEN 15
// first converter channel number served by port d pin 0
`define PPT_CHAN_BASE_D 5'h08
`define PPT_PRESC_EXT 3'h7
`define PPT_PIN_TIMER_EXT_CLOCK_IN 6
`define PPT_RST_DIR 8'h00
`define PPT_RST_PERIPH 16'h0000
`endif

//--- ppt_ports.v
// parallel ports c, d and e with apb register access and pin sharing
`timescale 1ns/10ps
`default_nettype none
`include "ppt_defs.vh"
module ppt_ports #(
   parameter AW = 8
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [4:0] pin_c_in,
   output reg [4:0] pin_c_out,
   output reg [4:0] pin_c_oe_n,
   input wire [6:0] pin_d_in,
   output reg [6:0] pin_d_out,
   output reg [6:0] pin_d_oe_n,
   input wire [7:0] pin_e_in,
   output reg [7:0] pin_e_out,
   output reg [7:0] pin_e_oe_n,
   input wire spi_sck_out,
   input wire spi_sck_oe,
   input wire spi_mosi_out,
   input wire spi_mosi_oe,
   input wire spi_miso_out,
   input wire spi_miso_oe,
   input wire [1:0] tim_ch_out,
   input wire [1:0] tim_ch_oe,
   input wire sci_txd,
   output reg spi_sck_in,
   output reg spi_mosi_in,
   output reg spi_miso_in,
   output reg spi_ss_in,
   output reg [1:0] tim_ch_in,
   output reg sci_rxd,
   output reg timer_ext_clock_in,
   output reg [6:0] converter_input
);
   // register state
   reg [4:0] third_port_latch_q;
   reg [6:0] fourth_port_latch_q;
   reg [7:0] fifth_port_latch_q;
   reg [4:0] dir_c_bits_q;
   reg [6:0] dir_d_bits_q;
   reg [7:0] dir_e_bits_q;
   reg clock_out_enable_q;
   reg [15:0] periph_q;
   // pin synchronisers
   reg [4:0] c_s1_q;
   reg [4:0] c_s2_q;
   reg [6:0] d_s1_q;
   reg [6:0] d_s2_q;
   reg [7:0] e_s1_q;
   reg [7:0] e_s2_q;
   reg clk_div_q;
   wire [4:0] converter_channel_select;
   wire [2:0] timer_prescale_select;
   wire serial_periph_enable;
   wire serial_periph_master;
   wire mode_fault_enable;
   wire [1:0] edge_level_select0;
   wire [1:0] edge_level_select1;
   wire async_serial_enable;
   wire ss_used;
   wire timer_ext_clock_in_sel;
   wire [1:0] tch_used;
   wire [6:0] chan_sel_d;
   wire [7:0] idx;
   wire wr_en;
   reg [31:0] rd_d;
   reg rd_hit_d;
   reg [4:0] c_oe_d;
   reg [4:0] c_out_d;
   reg [7:0] e_oe_d;
   reg [7:0] e_out_d;
   integer i;
   integer j;
   wire [7:0] lat_c_next;
   wire [7:0] lat_d_next;
   wire [7:0] rd_c_w;

   // read mux for a port: latch where direction one, pin where zero
   function [7:0] port_read;
      input [7:0] dir;
      input [7:0] latch;
      input [7:0] pin;
      begin
         port_read = (dir & latch) | (~dir & pin);
      end
   endfunction

   // apply byte strobes to one byte of write data
   function [7:0] strobed;
      input [7:0] old;
      input [31:0] wd;
      input [3:0] st;
      input integer lane;
      begin
         strobed = st[lane] ? wd[lane*8 +: 8] : old;
      end
   endfunction

   assign converter_channel_select = periph_q[`PPT_PF_CHAN_HI:`PPT_PF_CHAN_LO];
   assign timer_prescale_select = periph_q[`PPT_PF_PRESC_HI:`PPT_PF_PRESC_LO];
   assign serial_periph_enable = periph_q[`PPT_PF_SPE];
   assign serial_periph_master = periph_q[`PPT_PF_SPMST];
   assign mode_fault_enable = periph_q[`PPT_PF_MODF];
   assign edge_level_select0 = periph_q[`PPT_PF_ELS0_LO +: 2];
   assign edge_level_select1 = periph_q[`PPT_PF_ELS1_LO +: 2];
   assign async_serial_enable = periph_q[`PPT_PF_SCIEN];
   assign timer_ext_clock_in_sel = (timer_prescale_select == `PPT_PRESC_EXT);
   // slave select owned unless spi off or master without mode fault
   assign ss_used = serial_periph_enable & ~(serial_periph_master & ~mode_fault_enable);
   assign tch_used = {|edge_level_select1, |edge_level_select0};

   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_chan
         assign chan_sel_d[g] = ({27'h0000000, converter_channel_select} ==
                                 (`PPT_CHAN_BASE_D + g));
      end
   endgenerate

   assign idx = {{(10-AW){1'b0}}, paddr[AW-1:2]};
   // a write lands at the access edge, where pready is sampled high
   assign wr_en = psel & penable & pwrite & pready;
   assign lat_c_next = strobed({3'h0, third_port_latch_q}, pwdata, pstrb, 0);
   assign lat_d_next = strobed({1'h0, fourth_port_latch_q}, pwdata, pstrb, 0);
   assign rd_c_w = port_read({3'h0, dir_c_bits_q}, {3'h0, third_port_latch_q},
                             {3'h0, c_s2_q});

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c_s1_q <= 5'h00;
         c_s2_q <= 5'h00;
         d_s1_q <= 7'h00;
         d_s2_q <= 7'h00;
         e_s1_q <= 8'h00;
         e_s2_q <= 8'h00;
      end else begin
         c_s1_q <= pin_c_in;
         c_s2_q <= c_s1_q;
         d_s1_q <= pin_d_in;
         d_s2_q <= d_s1_q;
         e_s1_q <= pin_e_in;
         e_s2_q <= e_s1_q;
      end
   end

   // data latches have no reset
   always @(posedge pclk) begin
      if (wr_en && idx == `PPT_IDX_LATCH_C)
         third_port_latch_q <= lat_c_next[4:0];
      if (wr_en && idx == `PPT_IDX_LATCH_D)
         fourth_port_latch_q <= lat_d_next[6:0];
      if (wr_en && idx == `PPT_IDX_LATCH_E)
         fifth_port_latch_q <= strobed(fifth_port_latch_q, pwdata, pstrb, 0);
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_c_bits_q <= 5'h00;
         clock_out_enable_q <= 1'b0;
         dir_d_bits_q <= 7'h00;
         dir_e_bits_q <= `PPT_RST_DIR;
         periph_q <= `PPT_RST_PERIPH;
      end else if (wr_en) begin
         case (idx)
            `PPT_IDX_DIR_C: begin
               if (pstrb[0]) begin
                  dir_c_bits_q <= pwdata[4:0];
                  clock_out_enable_q <= pwdata[`PPT_CLKOUT_BIT];
               end
            end
            `PPT_IDX_DIR_D: begin
               if (pstrb[0])
                  dir_d_bits_q <= pwdata[6:0];
            end
            `PPT_IDX_DIR_E: begin
               dir_e_bits_q <= strobed(dir_e_bits_q, pwdata, pstrb, 0);
            end
            `PPT_IDX_PERIPH: begin
               periph_q[7:0] <= strobed(periph_q[7:0], pwdata, pstrb, 0);
               periph_q[15:8] <= strobed(periph_q[15:8], pwdata, pstrb, 1);
            end
            default: begin
            end
         endcase
      end
   end

   // read data and answer; every access answers one cycle after setup
   always @* begin
      rd_d = 32'h00000000;
      rd_hit_d = 1'b1;
      case (idx)
         `PPT_IDX_LATCH_C:
            rd_d[4:0] = rd_c_w[4:0];
         `PPT_IDX_LATCH_D: begin
            for (i = 0; i < 7; i = i + 1) begin
               if (chan_sel_d[i] && !dir_d_bits_q[i])
                  rd_d[i] = 1'b0;
               else
                  rd_d[i] = dir_d_bits_q[i] ? fourth_port_latch_q[i] : d_s2_q[i];
            end
         end
         `PPT_IDX_LATCH_E:
            rd_d[7:0] = port_read(dir_e_bits_q, fifth_port_latch_q, e_s2_q);
         `PPT_IDX_DIR_C: begin
            rd_d[4:0] = dir_c_bits_q;
            rd_d[`PPT_CLKOUT_BIT] = clock_out_enable_q;
         end
         `PPT_IDX_DIR_D: rd_d[6:0] = dir_d_bits_q;
         `PPT_IDX_DIR_E: rd_d[7:0] = dir_e_bits_q;
         `PPT_IDX_PERIPH: rd_d[15:0] = periph_q;
         `PPT_IDX_PINS: rd_d[19:0] = {e_s2_q, d_s2_q, c_s2_q};
         default: rd_hit_d = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~pready;
         pslverr <= psel & ~pready & ~rd_hit_d;
         if (psel && !pready && !pwrite)
            prdata <= rd_d;
      end
   end

   // pad drive for port c; pin 2 toggles at half pclk as the registered bus clock
   always @* begin
      c_oe_d = dir_c_bits_q;
      c_out_d = third_port_latch_q;
      if (clock_out_enable_q) begin
         c_oe_d[`PPT_CLKOUT_PIN] = 1'b1;
         c_out_d[`PPT_CLKOUT_PIN] = clk_div_q;
      end
   end

   always @* begin
      e_oe_d = dir_e_bits_q;
      e_out_d = fifth_port_latch_q;
      if (serial_periph_enable) begin
         e_oe_d[7:5] = {spi_sck_oe, spi_mosi_oe, spi_miso_oe};
         e_out_d[7:5] = {spi_sck_out, spi_mosi_out, spi_miso_out};
      end
      if (ss_used) begin
         e_oe_d[4] = 1'b0;
      end
      for (j = 0; j < 2; j = j + 1) begin
         if (tch_used[j]) begin
            e_oe_d[2+j] = tim_ch_oe[j];
            e_out_d[2+j] = tim_ch_out[j];
         end
      end
      if (async_serial_enable) begin
         e_oe_d[1:0] = 2'b01;
         e_out_d[1:0] = {1'b0, sci_txd};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_div_q <= 1'b0;
         pin_c_out <= 5'h00;
         pin_c_oe_n <= 5'h1F;
         pin_d_out <= 7'h00;
         pin_d_oe_n <= 7'h7F;
         pin_e_out <= 8'h00;
         pin_e_oe_n <= 8'hFF;
         spi_sck_in <= 1'b0;
         spi_mosi_in <= 1'b0;
         spi_miso_in <= 1'b0;
         spi_ss_in <= 1'b1;
         tim_ch_in <= 2'h0;
         sci_rxd <= 1'b1;
         timer_ext_clock_in <= 1'b0;
         converter_input <= 7'h00;
      end else begin
         clk_div_q <= ~clk_div_q;
         pin_c_out <= c_out_d;
         pin_c_oe_n <= ~c_oe_d;
         pin_d_out <= fourth_port_latch_q;
         // the selected converter channel pin, and pin 6 while the timer takes its external clock, are never driven
         pin_d_oe_n <= ~(dir_d_bits_q & ~chan_sel_d &
                         ~({timer_ext_clock_in_sel, 6'h00}));
         pin_e_out <= e_out_d;
         pin_e_oe_n <= ~e_oe_d;
         spi_sck_in <= e_s2_q[7];
         spi_mosi_in <= e_s2_q[6];
         spi_miso_in <= e_s2_q[5];
         spi_ss_in <= ss_used ? e_s2_q[4] : 1'b1;
         tim_ch_in <= e_s2_q[3:2] & tch_used;
         sci_rxd <= async_serial_enable ? e_s2_q[1] : 1'b1;
         timer_ext_clock_in <= timer_ext_clock_in_sel & d_s2_q[`PPT_PIN_TIMER_EXT_CLOCK_IN];
         converter_input <= d_s2_q & chan_sel_d;
      end
   end
endmodule // ppt_ports
`default_nettype wire

//--- ppt_ports_sva.sv
// assertions on the apb and pad ports of the parallel port block
`timescale 1ns/10ps
`default_nettype none
`include "ppt_defs.vh"
module ppt_chk #(
   parameter AW = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [4:0] pin_c_oe_n,
   input wire logic [6:0] pin_d_oe_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] wd_q;
   always_ff @(posedge pclk) begin
      if (psel && penable && pwrite) wd_q <= pwdata[7:0];
   end
   sequence s_setup; psel && !penable; endsequence
   sequence s_dcw; psel && penable && pwrite && {2'h0, paddr[7:2]} == `PPT_IDX_DIR_C; endsequence
   property p_ready; s_setup |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no pready after setup");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
   property p_idle; !psel |=> !pready; endproperty
   a_idle: assert property (p_idle) else $error("pready without request");
   property p_err; pslverr |-> pready && psel && penable; endproperty
   a_err: assert property (p_err) else $error("pslverr outside access");
   property p_rst; $rose(presetn) |-> &pin_c_oe_n && &pin_d_oe_n; endproperty
   a_rst: assert property (p_rst) else $error("pad driven after reset");
   property p_dirc;
      s_dcw |-> ##[1:2] {pin_c_oe_n[4:3], pin_c_oe_n[1:0]} == ~{wd_q[4:3], wd_q[1:0]};
   endproperty
   a_dirc: assert property (p_dirc) else $error("port c drivers ignore direction");
   property p_rdc;
      pready && !pwrite && {2'h0, paddr[7:2]} == `PPT_IDX_LATCH_C |-> prdata[31:5] == 27'h0;
   endproperty
   a_rdc: assert property (p_rdc) else $error("unused port c bits read nonzero");
   property p_rderr; pslverr && !pwrite |-> prdata == 32'h0; endproperty
   a_rderr: assert property (p_rderr) else $error("refused read returns data");
endmodule // ppt_chk
bind ppt_ports ppt_chk #(.AW(AW)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .pin_c_oe_n, .pin_d_oe_n);
`default_nettype wire

//--- ppt_board.sv
// board side of the pads: a driven pad shows the driver, an undriven one the board level
`timescale 1ns/10ps
`default_nettype none
module ppt_board (
   input wire logic [4:0] pin_c_out,
   input wire logic [4:0] pin_c_oe_n,
   input wire logic [6:0] pin_d_out,
   input wire logic [6:0] pin_d_oe_n,
   input wire logic [7:0] pin_e_out,
   input wire logic [7:0] pin_e_oe_n,
   input wire logic [4:0] ext_c,
   input wire logic [6:0] ext_d,
   input wire logic [7:0] ext_e,
   output logic [4:0] pin_c_in,
   output logic [6:0] pin_d_in,
   output logic [7:0] pin_e_in
);
   assign pin_c_in = (~pin_c_oe_n & pin_c_out) | (pin_c_oe_n & ext_c);
   assign pin_d_in = (~pin_d_oe_n & pin_d_out) | (pin_d_oe_n & ext_d);
   assign pin_e_in = (~pin_e_oe_n & pin_e_out) | (pin_e_oe_n & ext_e);
endmodule // ppt_board
`default_nettype wire

//--- parallel_ports_c_d_e_bench.sv
// self-checking bench for parallel ports c, d and e
`timescale 1ns/10ps
`default_nettype none
`include "ppt_defs.vh"
module parallel_ports_c_d_e_bench;
   localparam logic [7:0] LC = `PPT_IDX_LATCH_C << 2, LD = `PPT_IDX_LATCH_D << 2;
   localparam logic [7:0] LE = `PPT_IDX_LATCH_E << 2, DC = `PPT_IDX_DIR_C << 2;
   localparam logic [7:0] DD = `PPT_IDX_DIR_D << 2, DE = `PPT_IDX_DIR_E << 2;
   localparam logic [7:0] PF = `PPT_IDX_PERIPH << 2;
   localparam logic [72:0] ROWS [5] = '{{DC, 32'h7F, 32'h1F, 1'b0}, {DD, 32'hFF, 32'h7F, 1'b0},
      {DE, 32'hA5, 32'hA5, 1'b0}, {PF, 32'hFFFFFFFF, 32'hFFFF, 1'b0}, {8'h3C, 32'h55, 32'h0, 1'b1}};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, v;
   logic [7:0] paddr, pin_e_in, pin_e_out, pin_e_oe_n, ext_e;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [3:0] cnt_q = 4'h0;
   logic [4:0] pin_c_in, pin_c_out, pin_c_oe_n, ext_c;
   logic [6:0] pin_d_in, pin_d_out, pin_d_oe_n, ext_d, converter_input;
   logic [1:0] tim_ch_out, tim_ch_oe, tim_ch_in;
   logic spi_sck_out, spi_sck_oe, spi_mosi_out, spi_mosi_oe, spi_miso_out, spi_miso_oe;
   logic sci_txd, spi_sck_in, spi_mosi_in, spi_miso_in, spi_ss_in, sci_rxd, timer_ext_clock_in;
   int mismatches = 0;
   int total_checks = 0;
   ppt_ports dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .pin_c_in, .pin_c_out, .pin_c_oe_n, .pin_d_in, .pin_d_out, .pin_d_oe_n,
      .pin_e_in, .pin_e_out, .pin_e_oe_n, .spi_sck_out, .spi_sck_oe, .spi_mosi_out, .spi_mosi_oe,
      .spi_miso_out, .spi_miso_oe, .tim_ch_out, .tim_ch_oe, .sci_txd, .spi_sck_in, .spi_mosi_in,
      .spi_miso_in, .spi_ss_in, .tim_ch_in, .sci_rxd, .timer_ext_clock_in, .converter_input);
   ppt_board board (.pin_c_out, .pin_c_oe_n, .pin_d_out, .pin_d_oe_n, .pin_e_out, .pin_e_oe_n,
      .ext_c, .ext_d, .ext_e, .pin_c_in, .pin_d_in, .pin_e_in);
   // on-chip peripherals: always driving, with changing levels
   always @(posedge pclk) cnt_q <= cnt_q + 4'h1;
   assign {sci_txd, tim_ch_out, spi_sck_out} = cnt_q;
   assign {spi_mosi_out, spi_miso_out} = cnt_q[2:1];
   assign {spi_sck_oe, spi_mosi_oe, spi_miso_oe, tim_ch_oe} = 5'h1F;
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      mismatches++;
      print_verdict;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {pstrb, ext_c, ext_d, ext_e} = {4'hF, 5'h0A, 7'h7F, 8'h3C};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(DC, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(DD, 1'b0, 32'h0);
      chk({rd[7:0], pin_c_oe_n, pin_d_oe_n}, 20'h00FFF);
      for (int i = 0; i < 5; i++) begin
         apb(ROWS[i][72:65], 1'b1, ROWS[i][64:33]);
         apb(ROWS[i][72:65], 1'b0, 32'h0);
         chk(rd, ROWS[i][32:1]);
         chk(er, ROWS[i][0]);
      end
      apb(LC, 1'b1, 32'h15);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(DC, 1'b1, 32'h03);
      repeat (4) @(posedge pclk);
      chk({pin_c_oe_n, pin_c_out[1:0]}, 7'h71);
      apb(LC, 1'b0, 32'h0);
      chk(rd, 32'h09);
      apb(LC, 1'b1, 32'h0);
      apb(LC, 1'b0, 32'h0);
      chk(rd, 32'h08);
      apb(DC, 1'b1, 32'h80);
      repeat (4) @(posedge pclk);
      v = pin_c_out[2];
      chk(pin_c_oe_n, 5'h1B);
      @(posedge pclk);
      chk(pin_c_out[2], {31'h0, ~v});
      apb(LD, 1'b1, 32'h7F);
      apb(PF, 1'b1, 32'h0B);
      repeat (4) @(posedge pclk);
      apb(LD, 1'b0, 32'h0);
      chk(rd, 32'h77);
      apb(DD, 1'b1, 32'h7F);
      apb(PF, 1'b1, 32'hEB);
      repeat (4) @(posedge pclk);
      chk(pin_d_oe_n, 7'h48);
      apb(LD, 1'b0, 32'h0);
      chk(rd, 32'h7F);
      chk(timer_ext_clock_in, 1'b1);
      chk(converter_input, 7'h08);
      chk(pin_d_out, 7'h7F);
      ext_d <= 7'h3F;
      repeat (4) @(posedge pclk);
      chk(timer_ext_clock_in, 1'b0);
      apb(LE, 1'b1, 32'h0);
      apb(DE, 1'b1, 32'h01);
      apb(PF, 1'b1, 32'h8000);
      repeat (4) @(posedge pclk);
      apb(LE, 1'b0, 32'h0);
      chk(rd, 32'h3C);
      chk({pin_e_oe_n[1:0], sci_rxd}, 3'h4);
      apb(PF, 1'b1, 32'h0);
      repeat (4) @(posedge pclk);
      chk(pin_e_oe_n, 8'hFE);
      apb(DE, 1'b1, 32'h10);
      apb(PF, 1'b1, 32'h0B00);
      repeat (4) @(posedge pclk);
      chk({pin_e_oe_n[7], pin_e_oe_n[4:2]}, 4'h2);
      chk(spi_ss_in, 1'b1);
      ext_e <= 8'h2C;
      apb(PF, 1'b1, 32'h0F00);
      repeat (4) @(posedge pclk);
      chk(pin_e_oe_n[4], 1'b1);
      chk(spi_ss_in, 1'b0);
      print_verdict;
   end
endmodule // parallel_ports_c_d_e_bench
`default_nettype wire
